// file: core/rvs_pkg.sv
//Operation
// - Live ramp velocity reads back as 24-bit signed, zero after reset.
// - A negative readback velocity means motion toward lower positions.
// - An 18-bit unsigned start velocity, capped at target, is the speed a positioning move starts from.
// - Between start and threshold velocity the 18-bit first accel applies in positioning mode.
// - A 20-bit unsigned threshold velocity splits first and second phases.
// - A zero threshold skips the first phases, using second accel and decel.
// - Above the threshold the second accel applies, also in velocity mode.
// - Slowing from target down to the threshold uses the second decel in positioning mode and on stops.
// - Select zero is positioning; other codes run velocity modes or hold.
package rvs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_VEL_NOW   = 6'h22;
  localparam logic [5:0] IDX_START_VEL = 6'h23;
  localparam logic [5:0] IDX_FIRST_ACC = 6'h24;
  localparam logic [5:0] IDX_PHASE_VEL = 6'h25;

  // Field widths
  localparam int VEL_W   = 24;
  localparam int START_W = 18;
  localparam int ACC_W   = 18;
  localparam int PHASE_W = 20;
  localparam int TGT_W   = 23;

  // Reset values
  localparam logic [17:0] START_VEL_RST = 18'h0_0000;
  localparam logic [17:0] FIRST_ACC_RST = 18'h0_0000;
  localparam logic [19:0] PHASE_VEL_RST = 20'h0_0000;
  localparam logic [22:0] VEL_MAG_RST   = 23'h00_0000;

  // Ramp select encodings
  localparam logic [1:0] SEL_POSITION = 2'h0;
  localparam logic [1:0] SEL_VEL_POS  = 2'h1;
  localparam logic [1:0] SEL_VEL_NEG  = 2'h2;
  localparam logic [1:0] SEL_HOLD     = 2'h3;

  // Acceleration update period
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACC_TICK_NS   = 40960;
  localparam int ACC_TICK_CYC  = ACC_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {RS_IDLE, RS_RUN, RS_STOP} rvs_state_t;

endpackage

// file: core/rvs_step_if.sv
`timescale 1ns/1ps
interface rvs_step_if;
  logic [23:0] cur;
  logic [23:0] goal;
  logic [23:0] rate;
  logic [23:0] nxt;
  modport calc (input cur, input goal, input rate, output nxt);
  modport user (output cur, output goal, output rate, input nxt);
endinterface

// file: core/rvs_ramp_step.sv
`timescale 1ns/1ps
module rvs_ramp_step
  import rvs_pkg::*;
(
  // Step operands
  rvs_step_if.calc stp
);
  wire        goUp;
  wire [24:0] sumV;
  wire [24:0] difV;
  wire [23:0] upV;
  wire [23:0] downV;

  // Move cur toward goal by rate without overshoot
  assign goUp  = stp.cur < stp.goal;
  assign sumV  = {1'b0, stp.cur} + {1'b0, stp.rate};
  assign difV  = {1'b0, stp.cur} - {1'b0, stp.rate};
  assign upV   = (sumV >= {1'b0, stp.goal}) ? stp.goal : sumV[23:0];
  assign downV = (difV[24] || (difV[23:0] <= stp.goal)) ? stp.goal
                                                        : difV[23:0];
  assign stp.nxt = goUp ? upV : downV;
endmodule // rvs_ramp_step

// file: core/rvs_top.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module rvs_top
  import rvs_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // Ramp generator side
  input  wire logic [1:0]         rampSelect,
  input  wire logic [TGT_W-1:0]   targetVelocity,
  input  wire logic [ACC_W-1:0]   secondAccel,
  input  wire logic [ACC_W-1:0]   secondDecel,
  input  wire logic [ACC_W-1:0]   firstDecel,
  input  wire logic [START_W-1:0] stopVelocity,
  input  wire logic               moveReq,
  input  wire logic               moveDir,
  input  wire logic               stopReq,
  // Ramp state
  output logic      [VEL_W-1:0]   rampVelocityNow,
  output logic                    rampBusy
);
  logic [START_W-1:0] startVelocity_r;
  logic [ACC_W-1:0]   firstAccel_r;
  logic [PHASE_W-1:0] phaseThresholdVelocity_r;
  logic [TGT_W-1:0]   mag_r;
  logic [TGT_W-1:0]   mag_nxt;
  logic               dir_r;
  logic               dir_nxt;
  logic [VEL_W-1:0]   vel_r;
  logic [11:0]        tick_r;
  logic               ack_r;
  logic [31:0]        rdData_r;
  rvs_state_t         state_r;
  rvs_state_t         state_nxt;

  rvs_step_if stp ();

  rvs_ramp_step u_step (
    .stp (stp)
  );

  // Bus decode
  wire        req      = read | write;
  wire        wrTake   = write & ack_r;
  wire        hitVel   = address == {IDX_VEL_NOW, 2'b00};
  wire        hitStart = address == {IDX_START_VEL, 2'b00};
  wire        hitAcc   = address == {IDX_FIRST_ACC, 2'b00};
  wire        hitPhase = address == {IDX_PHASE_VEL, 2'b00};
  wire [31:0] rdMux    =
      hitVel   ? {{8{rampVelocityNow[23]}}, rampVelocityNow} :
      hitStart ? {14'h0000, startVelocity_r} :
      hitAcc   ? {14'h0000, firstAccel_r} :
      hitPhase ? {12'h000, phaseThresholdVelocity_r} : 32'h0000_0000;

  assign waitrequest = req & ~ack_r;
  assign readdata    = rdData_r;

  // Signed readback from next magnitude and direction
  wire [VEL_W-1:0] magExt  = {1'b0, mag_nxt};
  wire [VEL_W-1:0] vel_nxt =
      dir_nxt ? (~magExt + 24'h00_0001) : magExt;
  assign rampVelocityNow = vel_r;
  assign rampBusy        = state_r != RS_IDLE;

  // Acceleration time base
  wire        accTick  = tick_r == 12'(ACC_TICK_CYC - 1);
  wire [11:0] tick_nxt = accTick ? 12'h000 : tick_r + 12'h001;

  // Phase selection
  wire        phaseOn  = phaseThresholdVelocity_r != 20'h0_0000;
  wire        belowV1  = phaseOn &&
                         ({1'b0, mag_r} < {4'h0, phaseThresholdVelocity_r});
  wire [23:0] tgtExt   = {1'b0, targetVelocity};
  wire [23:0] curExt   = {1'b0, mag_r};
  wire        posMode  = rampSelect == SEL_POSITION;
  wire        velMode  = (rampSelect == SEL_VEL_POS) ||
                         (rampSelect == SEL_VEL_NEG);
  wire        velDir   = rampSelect == SEL_VEL_NEG;
  wire        reverse  = velMode && (dir_r != velDir) && (mag_r != '0);
  wire        atStopV  = {6'h00, mag_r} <= {6'h00, 5'h00, stopVelocity};
  wire [23:0] startCap = ({6'h00, startVelocity_r} < tgtExt)
                         ? {6'h00, startVelocity_r} : tgtExt;

  // Rate and goal for the step calculator
  wire [ACC_W-1:0] posRunRate =
      (curExt > tgtExt) ? (belowV1 ? firstDecel : secondDecel)
                        : (belowV1 ? firstAccel_r
                                   : secondAccel);
  wire [ACC_W-1:0] stopRate =
      (posMode && belowV1) ? firstDecel : secondDecel;
  wire [ACC_W-1:0] velRate  = secondAccel;
  wire             stopping = state_r == RS_STOP;

  assign stp.cur  = curExt;
  assign stp.goal = (stopping || reverse) ? 24'h00_0000 :
                    (rampSelect == SEL_HOLD) ? curExt : tgtExt;
  assign stp.rate = stopping ? {6'h00, stopRate} :
                    posMode  ? {6'h00, posRunRate} :
                    velMode  ? {6'h00, velRate} : 24'h00_0000;

  // Ramp sequencing
  always_comb begin
    state_nxt = state_r;
    mag_nxt   = mag_r;
    dir_nxt   = dir_r;
    unique case (state_r)
      RS_IDLE: begin
        if (posMode && moveReq) begin
          mag_nxt   = startCap[TGT_W-1:0];
          dir_nxt   = moveDir;
          state_nxt = RS_RUN;
        end else if (velMode && targetVelocity != '0) begin
          dir_nxt   = velDir;
          state_nxt = RS_RUN;
        end
      end
      RS_RUN: begin
        if (stopReq) begin
          state_nxt = RS_STOP;
        end else if (accTick) begin
          mag_nxt = stp.nxt[TGT_W-1:0];
          if (velMode && mag_r == '0) begin
            dir_nxt = velDir;
          end
        end
      end
      RS_STOP: begin
        if (mag_r == '0 || (posMode && belowV1 && atStopV) ||
            (posMode && !phaseOn && atStopV)) begin
          mag_nxt   = '0;
          state_nxt = RS_IDLE;
        end else if (accTick) begin
          mag_nxt = stp.nxt[TGT_W-1:0];
        end
      end
    endcase
  end

  // State, magnitude and direction registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= RS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mag_r <= VEL_MAG_RST;
    end else begin
      mag_r <= mag_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dir_r <= 1'b0;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // Registered signed velocity, zero in reset
  always_ff @(posedge clock) begin
    if (rst) begin
      vel_r <= {1'b0, VEL_MAG_RST};
    end else begin
      vel_r <= vel_nxt;
    end
  end

  // Free-running acceleration tick divider
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_r <= 12'h000;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  // Bus handshake: one wait cycle, read data captured during it
  wire rdTake = read & ~ack_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_r <= 32'h0000_0000;
    end else if (rdTake) begin
      rdData_r <= rdMux;
    end
  end

  // Setting registers
  wire wrStart = wrTake & hitStart;
  wire wrAcc   = wrTake & hitAcc;
  wire wrPhase = wrTake & hitPhase;

  always_ff @(posedge clock) begin
    if (rst) begin
      startVelocity_r <= START_VEL_RST;
    end else if (wrStart) begin
      startVelocity_r <= writedata[START_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      firstAccel_r <= FIRST_ACC_RST;
    end else if (wrAcc) begin
      firstAccel_r <= writedata[ACC_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phaseThresholdVelocity_r <= PHASE_VEL_RST;
    end else if (wrPhase) begin
      phaseThresholdVelocity_r <= writedata[PHASE_W-1:0];
    end
  end
endmodule // rvs_top

// file: sim/rvs_checker.sv
`timescale 1ns/1ps
module rvs_checker
  import rvs_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst,
  // Register bus
  input wire logic [7:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  // Ramp side
  input wire logic [1:0]       rampSelect,
  input wire logic             moveReq,
  input wire logic             moveDir,
  input wire logic             stopReq,
  input wire logic [VEL_W-1:0] rampVelocityNow,
  input wire logic             rampBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_rd(logic [7:0] a);
    read && !waitrequest && address == a;
  endsequence
  sequence s_go(logic d);
    moveReq && !rampBusy && rampSelect == SEL_POSITION && moveDir == d;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> !waitrequest)
    else $error("request waited more than one cycle");
  AST_NO_REQ: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  AST_RST_ZERO: assert property ($fell(rst) |-> !rampBusy)
    else $error("busy after reset");
  AST_RD_VEL: assert property (s_rd(8'h88) |->
    readdata == 32'($signed($past(rampVelocityNow))))
    else $error("velocity readback wrong");
  AST_RD_NARROW: assert property (read && !waitrequest &&
    address inside {8'h8C, 8'h90} |-> readdata[31:18] == '0)
    else $error("upper bits set");
  AST_RD_PHASE: assert property (
    s_rd(8'h94) |-> readdata[31:20] == '0)
    else $error("threshold upper bits set");
  AST_GO: assert property (s_go(1'b0) |=> rampBusy[*2])
    else $error("move not started");
  AST_DIR_NEG: assert property (s_go(1'b1) |=>
    $signed(rampVelocityNow) <= 0)
    else $error("velocity sign wrong");
  AST_IDLE_STOP: assert property (
    !rampBusy && stopReq && !moveReq |=> !rampBusy)
    else $error("stop started motion");
  AST_IDLE_ZERO: assert property (
    !rampBusy |-> rampVelocityNow == '0)
    else $error("velocity not zero while idle");
endmodule // rvs_checker

// file: sim/rvs_top_test.sv
`timescale 1ns/1ps
module rvs_top_test;
  import rvs_pkg::*;
  logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic moveReq = 1'b0, moveDir = 1'b0, stopReq = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd;
  logic waitrequest, rampBusy;
  logic [1:0] rampSelect = SEL_POSITION;
  logic [TGT_W-1:0] targetVelocity = 23'h00_1000;
  logic [ACC_W-1:0] secondAccel = 18'h0_0020, secondDecel = 18'h0_0040;
  logic [ACC_W-1:0] firstDecel = 18'h0_0040;
  logic [START_W-1:0] stopVelocity = 18'h0_0100;
  logic [VEL_W-1:0] rampVelocityNow, v0;
  logic [7:0] addr [5] = '{8'h88, 8'h8C, 8'h90, 8'h94, 8'h98};
  logic [31:0] mask [5] = '{32'h0, 32'h0003_FFFF, 32'h0003_FFFF,
                            32'h000F_FFFF, 32'h0};
  int n_errors = 0, checked = 0, cyc = 0;
  rvs_top u_dut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rampSelect(rampSelect),
    .targetVelocity(targetVelocity), .secondAccel(secondAccel),
    .secondDecel(secondDecel), .firstDecel(firstDecel),
    .stopVelocity(stopVelocity), .moveReq(moveReq), .moveDir(moveDir),
    .stopReq(stopReq), .rampVelocityNow(rampVelocityNow),
    .rampBusy(rampBusy));
  initial forever #20 clock = ~clock;
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic kick(input logic s, input logic d);
    @(posedge clock);
    moveReq <= ~s;
    stopReq <= s;
    moveDir <= d;
    @(posedge clock);
    moveReq <= 1'b0;
    stopReq <= 1'b0;
    @(negedge clock);
  endtask
  task automatic waitV(input logic idle);
    v0 = rampVelocityNow;
    while (idle ? (rampBusy !== 1'b0) : (rampVelocityNow === v0))
      @(negedge clock);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, addr[i], '0);
      chk(rd, '0);
      bus(1'b1, addr[i], 32'hFFFF_FFFF);
      bus(1'b0, addr[i], '0);
      chk(rd, mask[i]);
    end
    $display("register test done");
    bus(1'b1, 8'h8C, 32'h0000_0100);
    bus(1'b1, 8'h90, 32'h0000_0010);
    bus(1'b1, 8'h94, 32'h0000_0200);
    kick(1'b0, 1'b1);
    chk({8'h00, rampVelocityNow}, 32'h00FF_FF00);
    waitV(1'b0);
    chk({8'h00, rampVelocityNow}, 32'h00FF_FEF0);
    bus(1'b0, 8'h88, '0);
    chk(rd, 32'hFFFF_FEF0);
    kick(1'b1, 1'b0);
    waitV(1'b1);
    chk({7'h00, rampBusy, rampVelocityNow}, '0);
    kick(1'b1, 1'b0);
    chk({7'h00, rampBusy, rampVelocityNow}, '0);
    $display("first phase test done");
    bus(1'b1, 8'h94, '0);
    kick(1'b0, 1'b0);
    waitV(1'b0);
    chk({8'h00, rampVelocityNow}, 32'h0000_0120);
    kick(1'b1, 1'b0);
    waitV(1'b1);
    chk({7'h00, rampBusy, rampVelocityNow}, '0);
    $display("zero threshold test done");
    @(posedge clock);
    rampSelect <= SEL_VEL_NEG;
    waitV(1'b0);
    chk({8'h00, rampVelocityNow}, 32'h00FF_FFE0);
    @(posedge clock);
    rampSelect <= SEL_HOLD;
    repeat (1100) @(negedge clock);
    chk({8'h00, rampVelocityNow}, 32'h00FF_FFE0);
    kick(1'b1, 1'b0);
    waitV(1'b1);
    chk({7'h00, rampBusy, rampVelocityNow}, '0);
    $display("velocity mode test done");
    complete_run();
  end
endmodule // rvs_top_test
bind rvs_top rvs_checker u_chk (.clock(clock), .rst(rst), .address(address),
  .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .rampSelect(rampSelect), .moveReq(moveReq),
  .moveDir(moveDir), .stopReq(stopReq), .rampVelocityNow(rampVelocityNow),
  .rampBusy(rampBusy));
